// ### src/hlis_defines.svh
`ifndef HLIS_DEFINES_SVH
`define HLIS_DEFINES_SVH

// ====================================================================
// Register byte offsets on the APB slave.
`define HLIS_PCTL_OFS       12'h000
`define HLIS_PKIND_OFS      12'h004
`define HLIS_CFG_OFS        12'h008
`define HLIS_STAT_OFS       12'h00c

// ====================================================================
// Field positions in power_save_control.
`define HLIS_PCTL_WDT_MASK  6
`define HLIS_PCTL_NMI_MASK  5
`define HLIS_PCTL_INT_MASK  4
`define HLIS_PCTL_STBY_REQ  1
// Writable bits of power_save_control; the others read as zero.
`define HLIS_PCTL_WMASK     8'h72
// Field positions in power_save_kind_reg.
`define HLIS_PKIND_HI       1
`define HLIS_PKIND_LO       0
`define HLIS_PKIND_WMASK    8'h03
// Standby kind that selects light idle.
`define HLIS_KIND_LIGHT     2'h0
// Field positions in the clock configuration register.
`define HLIS_CFG_SUBCLK     0
`define HLIS_CFG_EVT_SUB    1
`define HLIS_CFG_WDT_INT    2
`define HLIS_CFG_WMASK      8'h07

// ====================================================================
// Reset values.
`define HLIS_PCTL_RST       8'h00
`define HLIS_PKIND_RST      8'h00
`define HLIS_CFG_RST        8'h00

`endif

// ### src/hlis_pkg.sv
`default_nettype none

package hlis_pkg;

  // ==================================================================
  // Standby controller modes; halt, wake and normal follow one path.
  typedef enum logic [1:0] {
    HLIS_NORMAL = 2'b00,
    HLIS_HALT   = 2'b01,
    HLIS_WAKE   = 2'b11,
    HLIS_LIDLE  = 2'b10
  } hlis_mode_t;

  // ==================================================================
  // Clock enables handed to the clock tree.
  typedef struct packed {
    logic cpu;
    logic periph;
    logic osc;
    logic pll;
    logic flash;
    logic subPeriph;
    logic eventTimer;
    logic watchdog2;
  } hlis_clk_t;

  // ==================================================================
  // How the CPU resumes after a wake-up.
  typedef struct packed {
    logic branch;
    logic nextInstr;
    logic ack;
  } hlis_resume_t;

endpackage

`default_nettype wire

// ### src/hlis_standby.sv
// Contract
// - Halt instruction stops only the CPU clock; peripherals keep their clocks. Halt here also gates event timer and watchdog2 per cfg without subclock.
// - Halt entered with an unmasked request pending exits again at once.
// - Halt ends on NMI pin, watchdog, unmasked pin or running-peripheral request, reset.
// - Reset sources are reset pin, watchdog reset, low-voltage detector, clock monitor.
// - After halt ends the device returns to normal mode.
// - Any non-maskable or unmasked request ends halt regardless of priority.
// - Lower-priority request during a handler wakes, is not acknowledged, stays pending.
// - Higher-priority or non-maskable request during a handler wakes and is acknowledged.
// - Non-maskable wake always branches to the handler.
// - Maskable wake: disabled resumes next instruction; enabled branches or continues.
// - A reset that ends halt behaves exactly as an ordinary reset.
// - Halt stops the CPU; oscillators, PLL and general peripherals keep running.
// - Without subclock, event timer and watchdog2 run only off other clocks.
// - During halt ports hold their state and internal data is preserved.
// - Light idle entered by kind zero then standby request bit set in normal.
// - Light idle keeps oscillator, PLL, flash; stops CPU and peripheral clocks.
// - Light idle keeps subclock or external clocked peripherals and RAM running.
// - Light idle release resumes normal at once, with no stabilisation wait.
// - Light idle requested with an unmasked request pending exits immediately.
// - Light idle ends on unmasked sources or reset, then normal resumes.
// - The three wake-mask bits do not affect release from halt.
// - A request blocked by its wake-mask bit does not end light idle.
//
// The APB slave port and the register addresses are this design's own decisions.
`include "hlis_defines.svh"
`default_nettype none

module hlis_standby
  import hlis_pkg::*;
#(
  parameter int EXT_IRQS = 9,
  parameter int PER_IRQS = 8,
  parameter int PRIO_W   = 3
) (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // APB slave.
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic      [31:0]         prdata,
  // CPU core.
  input  wire logic                haltExec,
  input  wire logic                irqEnabledState,
  output hlis_resume_t             resume,
  // Wake sources; pin inputs are asynchronous.
  input  wire logic                nmiPin,
  input  wire logic                watchdogNonmaskIrq,
  input  wire logic [EXT_IRQS-1:0] externalPinIrqs,
  input  wire logic [EXT_IRQS-1:0] extIrqMasked,
  input  wire logic [PER_IRQS-1:0] periphIrq,
  input  wire logic [PER_IRQS-1:0] periphIrqMasked,
  input  wire logic [PER_IRQS-1:0] periphHaltRun,
  input  wire logic [PER_IRQS-1:0] periphIdleRun,
  // Interrupt controller priority view; a lower number is more urgent.
  input  wire logic                inService,
  input  wire logic [PRIO_W-1:0]   servicePrio,
  input  wire logic [PRIO_W-1:0]   requestPrio,
  // Reset sources; the pin is asynchronous and active low.
  input  wire logic                resetPin_n,
  input  wire logic                watchdogResetSignal,
  input  wire logic                lowVoltageDetector,
  input  wire logic                clockMonitor,
  // Clock tree, ports and system reset.
  output hlis_clk_t                clkEn,
  output logic                     portHold,
  output logic                     systemResetReq,
  output hlis_mode_t               standbyMode
);

  // ==================================================================
  // State.
  typedef struct packed {
    hlis_mode_t          mode;
    logic [7:0]          pctl;
    logic [7:0]          pkind;
    logic [7:0]          cfg;
    logic [31:0]         rdata;
    logic                nmiS1;
    logic                nmiS2;
    logic [EXT_IRQS-1:0] extS1;
    logic [EXT_IRQS-1:0] extS2;
    logic                rstS1;
    logic                rstS2;
    hlis_resume_t        resume;
    hlis_clk_t           clk;
    logic                portHold;
    logic                resetReq;
    logic                lastNonmask;
  } hlis_state_t;

  localparam hlis_clk_t CLK_RUN = '{cpu: 1'b1, periph: 1'b1, osc: 1'b1, pll: 1'b1,
                                   flash: 1'b1, subPeriph: 1'b1, eventTimer: 1'b1,
                                   watchdog2: 1'b1};

  localparam hlis_state_t RST_VAL = '{
    mode: HLIS_NORMAL, pctl: `HLIS_PCTL_RST, pkind: `HLIS_PKIND_RST, cfg: `HLIS_CFG_RST,
    rdata: 32'h0000_0000, nmiS1: 1'b0, nmiS2: 1'b0, extS1: '0, extS2: '0,
    rstS1: 1'b1, rstS2: 1'b1, resume: '0, clk: CLK_RUN, portHold: 1'b0,
    resetReq: 1'b0, lastNonmask: 1'b0};

  hlis_state_t st;
  hlis_state_t next_st;

  // ==================================================================
  // Wake and reset decoding, all on synchronised or same-clock signals.
  logic                nmiReq;
  logic                wdtReq;
  logic [EXT_IRQS-1:0] extReq;
  logic [PER_IRQS-1:0] perReq;
  logic                maskReqHalt;
  logic                maskReqIdle;
  logic                haltWake;
  logic                idleWake;
  logic                resetSrc;
  logic                apbWrite;
  logic                apbSetup;
  logic                mapped;
  logic                stbyWrite;
  logic                higherPrio;

  assign nmiReq = st.nmiS2;
  assign wdtReq = watchdogNonmaskIrq;
  assign extReq = st.extS2 & ~extIrqMasked;
  assign perReq = periphIrq & ~periphIrqMasked;
  // Only peripherals that still run in the current mode can raise a wake.
  assign maskReqHalt = (|extReq) | (|(perReq & periphHaltRun));
  assign maskReqIdle = (|extReq) | (|(perReq & periphIdleRun));
  // Halt ignores the wake-mask bits altogether.
  assign haltWake = nmiReq | wdtReq | maskReqHalt;
  assign idleWake = (nmiReq & ~st.pctl[`HLIS_PCTL_NMI_MASK])
                  | (wdtReq & ~st.pctl[`HLIS_PCTL_WDT_MASK])
                  | (maskReqIdle & ~st.pctl[`HLIS_PCTL_INT_MASK]);
  assign resetSrc = ~st.rstS2 | watchdogResetSignal
                  | lowVoltageDetector | clockMonitor;
  assign higherPrio = ~inService | (requestPrio < servicePrio);

  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  assign mapped   = (paddr == `HLIS_PCTL_OFS) || (paddr == `HLIS_PKIND_OFS)
                 || (paddr == `HLIS_CFG_OFS) || (paddr == `HLIS_STAT_OFS);
  assign stbyWrite = apbWrite && (paddr == `HLIS_PCTL_OFS)
                  && pwdata[`HLIS_PCTL_STBY_REQ];

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ==================================================================
  // Next-state logic.
  always_comb begin
    next_st = st;
    // Synchronisers: the first stage feeds only the second.
    next_st.nmiS1 = nmiPin;
    next_st.nmiS2 = st.nmiS1;
    next_st.extS1 = externalPinIrqs;
    next_st.extS2 = st.extS1;
    next_st.rstS1 = resetPin_n;
    next_st.rstS2 = st.rstS1;
    next_st.resume = '0;
    next_st.resetReq = 1'b0;

    // Register writes; masks written together with the request are ignored.
    if (apbWrite) begin
      case (paddr)
        `HLIS_PCTL_OFS: begin
          if (pwdata[`HLIS_PCTL_STBY_REQ]) begin
            next_st.pctl[`HLIS_PCTL_STBY_REQ] = 1'b1;
          end else begin
            next_st.pctl = pwdata[7:0] & `HLIS_PCTL_WMASK;
          end
        end
        `HLIS_PKIND_OFS: next_st.pkind = pwdata[7:0] & `HLIS_PKIND_WMASK;
        `HLIS_CFG_OFS:  next_st.cfg  = pwdata[7:0] & `HLIS_CFG_WMASK;
        default:        next_st.cfg  = st.cfg;
      endcase
    end

    // Read data is captured in the setup phase and held through access.
    if (apbSetup) begin
      case (paddr)
        `HLIS_PCTL_OFS:  next_st.rdata = {24'h000000, st.pctl};
        `HLIS_PKIND_OFS: next_st.rdata = {24'h000000, st.pkind};
        `HLIS_CFG_OFS:  next_st.rdata = {24'h000000, st.cfg};
        `HLIS_STAT_OFS: next_st.rdata = {29'h00000000, st.lastNonmask, st.mode};
        default:        next_st.rdata = 32'h0000_0000;
      endcase
    end

    case (st.mode)
      HLIS_NORMAL: begin
        if (haltExec) begin
          next_st.mode = HLIS_HALT;
        end else if (stbyWrite && (st.pkind[1:0] == `HLIS_KIND_LIGHT)) begin
          next_st.mode = HLIS_LIDLE;
        end else if (stbyWrite) begin
          // Deeper standby kinds are not served here; the request drops.
          next_st.pctl[`HLIS_PCTL_STBY_REQ] = 1'b0;
        end
      end
      HLIS_HALT, HLIS_LIDLE: begin
        // A request already pending wins on the first standby cycle.
        if ((st.mode == HLIS_HALT) ? haltWake : idleWake) begin
          next_st.mode = HLIS_WAKE;
          next_st.pctl[`HLIS_PCTL_STBY_REQ] = 1'b0;
          next_st.lastNonmask = nmiReq | wdtReq;
          if (nmiReq | wdtReq) begin
            next_st.resume.branch = 1'b1;
            next_st.resume.ack    = 1'b1;
          end else if (irqEnabledState && higherPrio) begin
            next_st.resume.branch = 1'b1;
            next_st.resume.ack    = 1'b1;
          end else begin
            // Masked by the CPU or outranked: continue, leave it pending.
            next_st.resume.nextInstr = 1'b1;
          end
        end
      end
      HLIS_WAKE: begin
        // No stabilisation wait: the main oscillator never stopped.
        next_st.mode = HLIS_NORMAL;
      end
      default: next_st.mode = HLIS_NORMAL;
    endcase

    // Clock enables follow the mode being entered.
    next_st.clk = CLK_RUN;
    next_st.portHold = 1'b0;
    case (next_st.mode)
      HLIS_HALT: begin
        next_st.clk.cpu = 1'b0;
        next_st.clk.eventTimer = st.cfg[`HLIS_CFG_SUBCLK]
                              | ~st.cfg[`HLIS_CFG_EVT_SUB];
        next_st.clk.watchdog2 = st.cfg[`HLIS_CFG_SUBCLK]
                             | ~st.cfg[`HLIS_CFG_WDT_INT];
        next_st.portHold = 1'b1;
      end
      HLIS_LIDLE: begin
        next_st.clk.cpu = 1'b0;
        next_st.clk.periph = 1'b0;
        next_st.clk.watchdog2 = 1'b0;
        // Only the event timer on the subclock keeps counting.
        next_st.clk.eventTimer = st.cfg[`HLIS_CFG_SUBCLK]
                              & st.cfg[`HLIS_CFG_EVT_SUB];
      end
      default: next_st.clk = CLK_RUN;
    endcase

    // Any reset source acts like the ordinary reset, synchronisers excepted.
    if (resetSrc) begin
      next_st = RST_VAL;
      next_st.nmiS1 = nmiPin;
      next_st.nmiS2 = st.nmiS1;
      next_st.extS1 = externalPinIrqs;
      next_st.extS2 = st.extS1;
      next_st.rstS1 = resetPin_n;
      next_st.rstS2 = st.rstS1;
      next_st.resetReq = 1'b1;
    end
  end

  // ==================================================================
  // State register.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= RST_VAL;
    end else begin
      st <= next_st;
    end
  end

  // Registered outputs.  CPU state and RAM are kept simply by gating the clock.
  assign prdata         = st.rdata;
  assign resume         = st.resume;
  assign clkEn          = st.clk;
  assign portHold       = st.portHold;
  assign systemResetReq = st.resetReq;
  assign standbyMode    = st.mode;

  // ==================================================================
  // Assertions.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence seqHaltEnter;
    (st.mode == HLIS_NORMAL) && haltExec && !resetSrc;
  endsequence

  sequence seqStandbyWake;
    (st.mode == HLIS_WAKE) ##1 (st.mode == HLIS_NORMAL);
  endsequence

  AST_HALT_ENTER: assert property (
    seqHaltEnter |=> (st.mode == HLIS_HALT) && !clkEn.cpu && clkEn.periph)
    else $error("Halt entry did not gate only the CPU clock.");

  AST_HALT_RUNNING: assert property (
    (st.mode == HLIS_HALT) |-> clkEn.osc && clkEn.pll && clkEn.periph && !clkEn.cpu)
    else $error("Halt clocks wrong.");

  AST_HALT_WAKE: assert property (
    (st.mode == HLIS_HALT) && haltWake && !resetSrc |=> seqStandbyWake)
    else $error("Halt not released by a request.");

  AST_PENDING_EXIT: assert property (
    seqHaltEnter ##1 (haltWake && !resetSrc) |=> (st.mode == HLIS_WAKE))
    else $error("Pending request did not end halt at once.");

  AST_IDLE_ENTER: assert property (
    (st.mode == HLIS_NORMAL) && !haltExec && stbyWrite && !resetSrc
      && (st.pkind[1:0] == `HLIS_KIND_LIGHT) |=> (st.mode == HLIS_LIDLE))
    else $error("Light idle not entered.");

  AST_IDLE_CLOCKS: assert property (
    (st.mode == HLIS_LIDLE) |-> !clkEn.cpu && !clkEn.periph && clkEn.osc
      && clkEn.pll && clkEn.flash && clkEn.subPeriph)
    else $error("Light idle clocks wrong.");

  AST_IDLE_MASKED: assert property (
    (st.mode == HLIS_LIDLE) && !idleWake && !resetSrc |=> (st.mode == HLIS_LIDLE))
    else $error("Masked request released light idle.");

  AST_NMI_BRANCH: assert property (
    (st.mode inside {HLIS_HALT, HLIS_LIDLE}) && nmiReq && !resetSrc
      && ((st.mode == HLIS_HALT) || !st.pctl[`HLIS_PCTL_NMI_MASK])
      |=> resume.branch && resume.ack && !resume.nextInstr ##1 (resume == '0))
    else $error("Non-maskable wake did not branch.");

  AST_LOW_PRIO: assert property (
    (st.mode == HLIS_HALT) && maskReqHalt && !nmiReq && !wdtReq && !resetSrc
      && inService && (requestPrio >= servicePrio) |=> resume.nextInstr && !resume.ack)
    else $error("Lower-priority request was acknowledged.");

  AST_RESET_SRC: assert property (
    resetSrc |=> systemResetReq && (st.mode == HLIS_NORMAL) && (st.pctl == `HLIS_PCTL_RST))
    else $error("Reset source did not reset the controller.");

  AST_PORT_HOLD: assert property (
    $rose(st.mode == HLIS_HALT) |-> portHold)
    else $error("Ports not held in halt.");

endmodule

`default_nettype wire

// ### dv/hlis_cpu_model.sv
`default_nettype none

// ====================================================================
// CPU core and interrupt controller as seen from the standby block.
module hlis_cpu_model
  import hlis_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Bench commands.
  input  wire logic       haltCmd,
  input  wire logic [7:0] irqSet,
  // Standby block side.
  input  wire hlis_resume_t resume,
  output logic            haltExec,
  output logic      [7:0] periphIrq
);
  logic [2:0] nopCount;

  // A halt blocks haltCmd for the five cycles after the one that follows it; a haltCmd held into that next cycle issues a second halt.
  // Requests stay pending until the core acknowledges one; a wake without
  // acknowledge must leave them standing.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      haltExec  <= 1'b0;
      nopCount  <= 3'h0;
      periphIrq <= 8'h00;
    end else begin
      haltExec <= haltCmd && (nopCount == 3'h0);
      if (haltExec) begin
        nopCount <= 3'h5;
      end else if (nopCount != 3'h0) begin
        nopCount <= nopCount - 3'h1;
      end
      periphIrq <= (periphIrq | irqSet) & ~{8{resume.ack}};
    end
  end
endmodule

`default_nettype wire

// ### dv/test_hlis_standby.sv
`include "hlis_defines.svh"
`default_nettype none

module test_hlis_standby
  import hlis_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==================================================================
  // Stimulus and observed signals.
  logic             sys_clk = 1'b0;
  logic             srst = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic      [11:0] paddr = 12'h000;
  logic      [31:0] pwdata = 32'h0;
  logic             irqEn = 1'b0;
  logic             nmiPin = 1'b0;
  logic             wdtIrq = 1'b0;
  logic       [8:0] extIrq = 9'h000;
  logic       [7:0] irqSet = 8'h00;
  logic             inService = 1'b0;
  logic       [2:0] servicePrio = 3'h0;
  logic       [2:0] requestPrio = 3'h0;
  logic       [3:0] rstSrc = 4'h0;
  logic             haltCmd = 1'b0;
  logic             pready;
  logic             pslverr;
  logic      [31:0] prdata;
  logic             haltExec;
  logic       [7:0] periphIrq;
  hlis_resume_t     resume;
  hlis_clk_t        clkEn;
  hlis_mode_t       standbyMode;
  logic             portHold;
  logic             systemResetReq;
  logic      [31:0] rd;
  logic             err;
  int               nFail = 0;
  int               checkCount = 0;
  int               cycles = 0;

  // The clock toggles every 2.5 ns, a period of 5 ns.
  always #2.5 sys_clk = ~sys_clk;

  hlis_standby DUT (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .haltExec(haltExec),
    .irqEnabledState(irqEn), .resume(resume), .nmiPin(nmiPin),
    .watchdogNonmaskIrq(wdtIrq), .externalPinIrqs(extIrq),
    .extIrqMasked(9'h000), .periphIrq(periphIrq), .periphIrqMasked(8'h00),
    .periphHaltRun(8'hff), .periphIdleRun(8'h00), .inService(inService),
    .servicePrio(servicePrio), .requestPrio(requestPrio),
    .resetPin_n(~rstSrc[0]), .watchdogResetSignal(rstSrc[1]),
    .lowVoltageDetector(rstSrc[2]), .clockMonitor(rstSrc[3]),
    .clkEn(clkEn), .portHold(portHold), .systemResetReq(systemResetReq),
    .standbyMode(standbyMode)
  );

  hlis_cpu_model cpu (
    .sys_clk(sys_clk), .srst(srst), .haltCmd(haltCmd), .irqSet(irqSet),
    .resume(resume), .haltExec(haltExec), .periphIrq(periphIrq)
  );

  // ==================================================================
  // Shared tasks.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits a bounded time for a mode, then compares it.
  task automatic waitMode(input hlis_mode_t m);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (standbyMode !== m && n < 30);
    check("mode", standbyMode, m);
  endtask

  task automatic doHalt();
    @(posedge sys_clk);
    haltCmd <= 1'b1;
    @(posedge sys_clk);
    haltCmd <= 1'b0;
  endtask

  // ==================================================================
  // Scenarios.
  task automatic testRegs();
    check("clk rst", clkEn, 32'h000000ff);
    apb(`HLIS_PCTL_OFS, 1'b0, 32'h0);
    check("ctl rst", rd, 32'h0);
    apb(`HLIS_PKIND_OFS, 1'b0, 32'h0);
    check("kind rst", rd, 32'h0);
    apb(12'h010, 1'b0, 32'h0);
    check("unmapped err", err, 32'h1);
    check("unmapped rd", rd, 32'h0);
    apb(`HLIS_CFG_OFS, 1'b1, 32'hffffffff);
    apb(`HLIS_CFG_OFS, 1'b0, 32'h0);
    check("cfg rw", rd, 32'h7);
    $display("test regs done");
  endtask

  // Event timer on subclock and watchdog2 on the internal oscillator stop.
  task automatic testHalt();
    apb(`HLIS_CFG_OFS, 1'b1, 32'h6);
    doHalt();
    waitMode(HLIS_HALT);
    check("halt clk", clkEn, 32'h7c);
    check("halt port", portHold, 32'h1);
    repeat (4) @(posedge sys_clk);
    #1;
    check("halt stays", standbyMode, HLIS_HALT);
    @(posedge sys_clk);
    extIrq <= 9'h008;
    waitMode(HLIS_WAKE);
    check("resume di", resume, 32'h2);
    @(posedge sys_clk);
    #1;
    check("normal", standbyMode, HLIS_NORMAL);
    check("clk back", clkEn, 32'hff);
    @(posedge sys_clk);
    extIrq <= 9'h000;
    apb(`HLIS_CFG_OFS, 1'b1, 32'h0);
    $display("test halt done");
  endtask

  // Wake masks are set but must not stop a release from halt.
  task automatic testNmi();
    apb(`HLIS_PCTL_OFS, 1'b1, 32'h70);
    doHalt();
    waitMode(HLIS_HALT);
    @(posedge sys_clk);
    nmiPin <= 1'b1;
    waitMode(HLIS_WAKE);
    check("resume nmi", resume, 32'h5);
    @(posedge sys_clk);
    nmiPin <= 1'b0;
    apb(`HLIS_PCTL_OFS, 1'b1, 32'h0);
    $display("test nmi done");
  endtask

  task automatic testPrio();
    irqEn <= 1'b1;
    inService <= 1'b1;
    servicePrio <= 3'h2;
    requestPrio <= 3'h5;
    doHalt();
    waitMode(HLIS_HALT);
    @(posedge sys_clk);
    irqSet <= 8'h01;
    @(posedge sys_clk);
    irqSet <= 8'h00;
    waitMode(HLIS_WAKE);
    check("resume low", resume, 32'h2);
    repeat (2) @(posedge sys_clk);
    #1;
    check("still pending", periphIrq, 32'h1);
    requestPrio <= 3'h1;
    doHalt();
    waitMode(HLIS_WAKE);
    check("resume high", resume, 32'h5);
    irqEn <= 1'b0;
    inService <= 1'b0;
    $display("test prio done");
  endtask

  task automatic testIdle();
    apb(`HLIS_PCTL_OFS, 1'b1, 32'h10);
    extIrq <= 9'h001;
    apb(`HLIS_PCTL_OFS, 1'b1, 32'h12);
    repeat (5) @(posedge sys_clk);
    #1;
    check("idle mode", standbyMode, HLIS_LIDLE);
    check("idle clk", clkEn, 32'h3c);
    @(posedge sys_clk);
    wdtIrq <= 1'b1;
    waitMode(HLIS_WAKE);
    @(posedge sys_clk);
    #1;
    check("idle normal", standbyMode, HLIS_NORMAL);
    @(posedge sys_clk);
    wdtIrq <= 1'b0;
    apb(`HLIS_PCTL_OFS, 1'b0, 32'h0);
    check("ctl after", rd, 32'h10);
    apb(`HLIS_PCTL_OFS, 1'b1, 32'h0);
    apb(`HLIS_PCTL_OFS, 1'b1, 32'h2);
    waitMode(HLIS_WAKE);
    @(posedge sys_clk);
    extIrq <= 9'h000;
    apb(`HLIS_PKIND_OFS, 1'b1, 32'h1);
    apb(`HLIS_PCTL_OFS, 1'b1, 32'h2);
    repeat (3) @(posedge sys_clk);
    #1;
    check("kind refused", standbyMode, HLIS_NORMAL);
    apb(`HLIS_PKIND_OFS, 1'b1, 32'h0);
    $display("test idle done");
  endtask

  // Each reset source in turn ends halt exactly as an ordinary reset.
  task automatic testReset();
    int n;
    for (int i = 0; i < 4; i++) begin
      doHalt();
      waitMode(HLIS_HALT);
      @(posedge sys_clk);
      rstSrc <= 4'h1 << i;
      n = 0;
      do begin
        @(posedge sys_clk);
        #1;
        n++;
      end while (systemResetReq !== 1'b1 && n < 10);
      check("rst req", systemResetReq, 32'h1);
      check("rst mode", standbyMode, HLIS_NORMAL);
      check("rst clk", clkEn, 32'hff);
      check("rst port", portHold, 32'h0);
      @(posedge sys_clk);
      rstSrc <= 4'h0;
      repeat (4) @(posedge sys_clk);
    end
    $display("test reset done");
  endtask

  // ==================================================================
  // Main sequence; reset is held for ten cycles first.
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    testRegs();
    testHalt();
    testNmi();
    testPrio();
    testIdle();
    testReset();
    wrap_up();
  end

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      wrap_up();
    end
  end
endmodule

`default_nettype wire
